/* File: rtl/card_mux_pkg.sv */
/*
  constants shared by the register bank of the dual card multiplexer.
  assumes an i2c slave core that presents byte-wide register accesses.

*/
package card_mux_pkg;
  localparam logic [7:0] ADDR_HW_REV = 8'h00;
  localparam logic [7:0] ADDR_SW_REV = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SLOT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_BAT_DEB = 8'h0a;
  localparam logic [7:0] ADDR_SDN_DEB = 8'h0b;
  localparam logic [7:0] ADDR_RSVD = 8'h0c;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h0d;
  localparam logic [7:0] ADDR_DEV_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_TEST_LO = 8'h10;
  localparam logic [7:0] ADDR_TEST_HI = 8'h14;
  localparam logic [7:0] ADDR_PULL_CFG = 8'h15;
  localparam logic [7:0] RST_DEB = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // arbitrary neutral identity values
  localparam logic [3:0] MAKER_CODE = 4'h5;
  localparam logic [3:0] HW_REV_CODE = 4'h1;
  localparam logic [7:0] SW_REV_CODE = 8'h03;
  // 7-bit slave address base; bit 0 comes from the strap
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h2a;
  // control field positions
  localparam int SLOT1_REG_EN = 0;
  localparam int SLOT1_STATE_LO = 2;
  localparam int SLOT2_REG_EN = 4;
  localparam int SLOT2_STATE_LO = 6;
  localparam int BAT_IRQ_EN = 2;
  localparam int SDN_IRQ_EN = 5;
  localparam logic [1:0] SLOT_DOWN = 2'h0;
  // status byte field positions
  localparam int STAT_SDN_FLAG = 1;
  localparam int STAT_BAT_FLAG = 3;
  localparam int STAT_SLOT1_LO = 4;
  localparam int STAT_SLOT2_LO = 6;
endpackage

/* File: rtl/card_mux_bus_if.sv */
/*
  byte register access bundle between the i2c slave and the bank.
  assumes one clock domain; strobes are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
interface card_mux_bus_if;
  logic wr_stb; // one-cycle write
  logic rd_stb; // one-cycle read, pulsed the cycle after the data is sampled
  logic [7:0] addr;
  logic [7:0] wdata; // write data; during a read pulse, the byte just fetched for sending
  logic [7:0] rdata;
  logic [6:0] slave_addr; // address the slave answers to
  modport bank (input wr_stb, rd_stb, addr, wdata, output rdata, slave_addr);
  modport slave (output wr_stb, rd_stb, addr, wdata, input rdata, slave_addr);
endinterface
`default_nettype wire

/* File: rtl/card_mux_i2c_slave.sv */
/*
  i2c slave: address byte, register pointer byte, then data bytes.
  assumes pins already passed through two flip-flops; pointer auto-increments.
*/
`timescale 1ns/1ns
`default_nettype none
module card_mux_i2c_slave
  import card_mux_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic sda_oe,
  card_mux_bus_if.slave bus
);
  typedef enum logic [4:0] {
    IDLE = 5'b00001, ADDR = 5'b00010, ACK = 5'b00100, WRB = 5'b01000, RDB = 5'b10000
  } phase_t;
  typedef struct packed {
    phase_t ph;
    logic scl_d;
    logic sda_d;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd_mode; // transfer is a read
    logic have_ptr; // pointer byte already received
    logic drive; // sda low
    logic ackd; // ack slot after a data byte we sent
    logic [7:0] ptr;
    logic wr;
    logic rd;
  } st_t;
  st_t s, next_s;
  logic rise, fall, start, stop;
  // edge and condition detection on already synchronised pins
  always_comb
  begin
    rise = scl_s & ~s.scl_d;
    fall = ~scl_s & s.scl_d;
    start = scl_s & s.scl_d & s.sda_d & ~sda_s;
    stop = scl_s & s.scl_d & ~s.sda_d & sda_s;
  end
  // protocol sequencing
  always_comb
  begin
    next_s = s;
    next_s.scl_d = scl_s;
    next_s.sda_d = sda_s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    if (start)
    begin
      next_s.ph = ADDR;
      next_s.bitn = 4'h0;
      next_s.drive = 1'b0;
      next_s.have_ptr = 1'b0;
    end
    else if (stop)
    begin
      next_s.ph = IDLE;
      next_s.drive = 1'b0;
    end
    else
    begin
      unique case (s.ph)
        IDLE: next_s.drive = 1'b0;
        ADDR, WRB:
        begin
          if (rise)
          begin
            next_s.sh = {s.sh[6:0], sda_s};
            next_s.bitn = s.bitn + 4'h1;
          end
          if (fall && s.bitn == 4'h8)
          begin
            next_s.bitn = 4'h0;
            next_s.ackd = 1'b0;
            if (s.ph == ADDR)
            begin
              // only our address gets an ack
              if (s.sh[7:1] == bus.slave_addr)
              begin
                next_s.rd_mode = s.sh[0];
                next_s.drive = 1'b1;
                next_s.ph = ACK;
              end
              else
                next_s.ph = IDLE;
            end
            else
            begin
              next_s.drive = 1'b1;
              next_s.ph = ACK;
              if (!s.have_ptr)
              begin
                next_s.ptr = s.sh;
                next_s.have_ptr = 1'b1;
              end
              else
              begin
                next_s.wr = 1'b1;
                next_s.ptr = s.ptr + 8'h01;
              end
            end
          end
        end
        ACK:
        begin
          if (fall)
          begin
            if (s.ackd && sda_s)
            begin
              // master nack ends the read
              next_s.drive = 1'b0;
              next_s.ph = IDLE;
            end
            else if (s.rd_mode)
            begin
              // read pulse lets the bank clear the status flags that the fetched byte carried
              next_s.rd = 1'b1;
              next_s.sh = bus.rdata;
              next_s.ptr = s.ptr + 8'h01;
              next_s.drive = ~bus.rdata[7];
              next_s.ph = RDB;
            end
            else
            begin
              next_s.drive = 1'b0;
              next_s.ph = WRB;
            end
          end
          else if (rise && s.ackd)
            next_s.drive = 1'b0;
        end
        RDB:
        begin
          if (fall)
          begin
            next_s.bitn = s.bitn + 4'h1;
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.drive = ~s.sh[6];
            if (s.bitn == 4'h7)
            begin
              next_s.drive = 1'b0;
              next_s.ackd = 1'b1;
              next_s.bitn = 4'h0;
              next_s.ph = ACK;
            end
          end
        end
        default: next_s.ph = IDLE;
      endcase
    end
  end
  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.ph <= IDLE;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
    end
    else
      s <= next_s;
  end
  assign sda_oe = s.drive;
  assign bus.wr_stb = s.wr;
  assign bus.rd_stb = s.rd;
  // both strobes come after the pointer has moved on, so they name the previous place
  assign bus.addr = (s.wr || s.rd) ? s.ptr - 8'h01 : s.ptr;
  assign bus.wdata = s.sh;
endmodule
`default_nettype wire

/* File: rtl/card_mux_regs.sv */
/*
  register bank of the dual card multiplexer: revision, status with
  debounced shutdown and battery sense, slot control and configuration.
  assumes the 32 khz tick and pins are raw; they are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module card_mux_regs
  import card_mux_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tick_32k,
  input wire logic shutdown_request_input,
  input wire logic battery_sense_input,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  input wire logic irq_in,
  output logic irq_out,
  output logic irq_oe,
  output logic [7:0] slot_control,
  output logic [7:0] device_control,
  output logic [7:0] clock_control,
  output logic [7:0] pull_config
);
  import card_mux_pkg::*;
  card_mux_bus_if bus ();
  typedef struct packed {
    logic [1:0] sdn_sy, bat_sy, scl_sy, sda_sy, tk_sy, irq_sy; // two-stage synchronisers
    logic tk_d;
    logic strapped; // address strap caught after release
    logic [1:0] strap_dly; // lets the pin synchroniser fill before the strap is taken
    logic addr_bit;
    logic [7:0] sdn_cnt, bat_cnt; // debounce counters
    logic sdn_run, bat_run;
    logic sdn_ref, bat_ref; // level being debounced
    logic sdn_stat, sdn_flag, bat_stat, bat_flag;
    logic [7:0] ctrl, bat_deb, sdn_deb, rsvd, clk_ctl, dev_ctl, pulls;
    logic [ADDR_TEST_HI - ADDR_TEST_LO:0][7:0] test; // packed so it fits the state struct
    logic irq;
    logic [7:0] rdata;
  } st_t;
  st_t s, next_s;
  logic sdn_exp, bat_exp, tick;

  function automatic logic [1:0] slot_view(input logic en, input logic [1:0] state);
    return en ? state : SLOT_DOWN;
  endfunction

  card_mux_i2c_slave u_slave (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .scl_s(s.scl_sy[1]),
    .sda_s(s.sda_sy[1]),
    .sda_oe(sda_oe),
    .bus(bus)
  );

  // status byte assembled from live state
  function automatic logic [7:0] status_byte(input st_t c);
    return {slot_view(c.ctrl[SLOT2_REG_EN], c.ctrl[SLOT2_STATE_LO +: 2]),
            slot_view(c.ctrl[SLOT1_REG_EN], c.ctrl[SLOT1_STATE_LO +: 2]),
            c.bat_flag, c.bat_stat, c.sdn_flag, c.sdn_stat};
  endfunction

  // next state
  always_comb
  begin
    next_s = s;
    next_s.sdn_sy = {s.sdn_sy[0], shutdown_request_input};
    next_s.bat_sy = {s.bat_sy[0], battery_sense_input};
    next_s.scl_sy = {s.scl_sy[0], scl_in};
    next_s.sda_sy = {s.sda_sy[0], sda_in};
    next_s.tk_sy = {s.tk_sy[0], tick_32k};
    next_s.irq_sy = {s.irq_sy[0], irq_in};
    next_s.tk_d = s.tk_sy[1];
    tick = s.tk_sy[1] & ~s.tk_d;
    // strap the slave address once the synchroniser holds real pin samples
    next_s.strap_dly = {s.strap_dly[0], 1'b1};
    if (!s.strapped && s.strap_dly[1])
    begin
      next_s.strapped = 1'b1;
      next_s.addr_bit = s.irq_sy[1];
    end
    // shutdown debounce: restart on any change, expiry captures level
    sdn_exp = 1'b0;
    if (s.sdn_sy[1] != s.sdn_ref)
    begin
      next_s.sdn_ref = s.sdn_sy[1];
      next_s.sdn_cnt = s.sdn_deb;
      next_s.sdn_run = 1'b1;
      sdn_exp = (s.sdn_deb == 8'h00);
      if (sdn_exp)
        next_s.sdn_run = 1'b0;
    end
    else if (s.sdn_run && tick)
    begin
      if (s.sdn_cnt <= 8'h01)
      begin
        sdn_exp = 1'b1;
        next_s.sdn_run = 1'b0;
      end
      else
        next_s.sdn_cnt = s.sdn_cnt - 8'h01;
    end
    // battery debounce counts only while sense reports absence
    bat_exp = 1'b0;
    if (s.bat_sy[1] != s.bat_ref)
    begin
      next_s.bat_ref = s.bat_sy[1];
      next_s.bat_cnt = s.bat_deb;
      next_s.bat_run = s.bat_sy[1];
      if (!s.bat_sy[1])
        next_s.bat_stat = 1'b0; // battery back
      else if (s.bat_deb == 8'h00)
      begin
        bat_exp = 1'b1;
        next_s.bat_run = 1'b0;
      end
    end
    else if (s.bat_run && tick)
    begin
      if (s.bat_cnt <= 8'h01)
      begin
        bat_exp = 1'b1;
        next_s.bat_run = 1'b0;
      end
      else
        next_s.bat_cnt = s.bat_cnt - 8'h01;
    end
    // read data and read-to-clear
    next_s.rdata = RST_ZERO;
    unique case (bus.addr)
      ADDR_HW_REV: next_s.rdata = {MAKER_CODE, HW_REV_CODE};
      ADDR_SW_REV: next_s.rdata = SW_REV_CODE;
      ADDR_STATUS: next_s.rdata = status_byte(s);
      ADDR_SLOT_CTRL: next_s.rdata = s.ctrl;
      ADDR_BAT_DEB: next_s.rdata = s.bat_deb;
      ADDR_SDN_DEB: next_s.rdata = s.sdn_deb;
      ADDR_RSVD: next_s.rdata = s.rsvd;
      ADDR_CLK_CTRL: next_s.rdata = s.clk_ctl;
      ADDR_DEV_CTRL: next_s.rdata = s.dev_ctl;
      ADDR_PULL_CFG: next_s.rdata = s.pulls;
      default:
        if (bus.addr >= ADDR_TEST_LO && bus.addr <= ADDR_TEST_HI)
          next_s.rdata = s.test[3'(bus.addr - ADDR_TEST_LO)];
    endcase
    // only flags that went out in the fetched byte are cleared; read data lags the
    // flags by a cycle, so an event after the fetch must survive the clear
    if (bus.rd_stb && bus.addr == ADDR_STATUS)
    begin
      if (bus.wdata[STAT_SDN_FLAG])
        next_s.sdn_flag = 1'b0;
      if (bus.wdata[STAT_BAT_FLAG])
        next_s.bat_flag = 1'b0;
    end
    // set wins over the read clear
    if (sdn_exp)
    begin
      next_s.sdn_stat = s.sdn_sy[1];
      next_s.sdn_flag = 1'b1;
    end
    if (bat_exp && !s.bat_stat)
    begin
      next_s.bat_stat = 1'b1;
      next_s.bat_flag = 1'b1;
    end
    // register writes; a debounce update restarts a running count
    if (bus.wr_stb)
    begin
      unique case (bus.addr)
        ADDR_SLOT_CTRL: next_s.ctrl = bus.wdata;
        ADDR_BAT_DEB:
        begin
          next_s.bat_deb = bus.wdata;
          if (s.bat_run)
            next_s.bat_cnt = bus.wdata;
        end
        ADDR_SDN_DEB:
        begin
          next_s.sdn_deb = bus.wdata;
          if (s.sdn_run)
            next_s.sdn_cnt = bus.wdata;
        end
        ADDR_RSVD: next_s.rsvd = bus.wdata;
        ADDR_CLK_CTRL: next_s.clk_ctl = bus.wdata;
        ADDR_DEV_CTRL: next_s.dev_ctl = bus.wdata;
        ADDR_PULL_CFG: next_s.pulls = bus.wdata;
        default:
          if (bus.addr >= ADDR_TEST_LO && bus.addr <= ADDR_TEST_HI)
            next_s.test[3'(bus.addr - ADDR_TEST_LO)] = bus.wdata;
      endcase
    end
    // interrupt pin is open-drain, asserted low while an enabled flag stands
    next_s.irq = (next_s.sdn_flag & s.dev_ctl[SDN_IRQ_EN]) |
                 (next_s.bat_flag & s.dev_ctl[BAT_IRQ_EN]);
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      // bus pins idle high; a zero here would show the slave a false edge
      s.scl_sy <= '1;
      s.sda_sy <= '1;
      s.bat_deb <= RST_DEB;
      s.sdn_deb <= RST_DEB;
    end
    else
      s <= next_s;
  end

  assign bus.rdata = s.rdata;
  assign bus.slave_addr = {SLAVE_ADDR_BASE[6:1], s.addr_bit};
  assign irq_out = 1'b0;
  assign irq_oe = s.irq;
  assign slot_control = s.ctrl;
  assign device_control = s.dev_ctl;
  assign clock_control = s.clk_ctl;
  assign pull_config = s.pulls;

  // a shutdown expiry must leave the flag set next cycle
  sdn_flag_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sdn_exp |=> s.sdn_flag) else $error("shutdown flag not set");
  // a status read that reported the battery flag clears it unless a new event lands
  bat_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bus.rd_stb && bus.addr == ADDR_STATUS && bus.wdata[STAT_BAT_FLAG] && !bat_exp) |=> !s.bat_flag)
    else $error("battery flag not cleared");
  // same for the shutdown flag
  sdn_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bus.rd_stb && bus.addr == ADDR_STATUS && bus.wdata[STAT_SDN_FLAG] && !sdn_exp) |=> !s.sdn_flag)
    else $error("shutdown flag not cleared");
  // regulator off forces slot one down in the read data
  slot_down_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bus.addr == ADDR_STATUS && !s.ctrl[SLOT1_REG_EN]) |=> s.rdata[STAT_SLOT1_LO +: $bits(SLOT_DOWN)] == SLOT_DOWN)
    else $error("slot one not down");
  // regulator off forces slot two down in the read data
  slot_two_down_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bus.addr == ADDR_STATUS && !s.ctrl[SLOT2_REG_EN]) |=> s.rdata[STAT_SLOT2_LO +: $bits(SLOT_DOWN)] == SLOT_DOWN)
    else $error("slot two not down");
  // the revision byte never changes, maker nibble included
  maker_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus.addr == ADDR_HW_REV |=> s.rdata == {MAKER_CODE, HW_REV_CODE})
    else $error("hardware revision changed");
endmodule
`default_nettype wire

/* File: dv/host_i2c_model.sv */
/*
  behavioural i2c master standing in for the baseband host.
  assumes scl and sda are pulled up in the bench; sda_low pulls sda down.
*/
`timescale 1ns/1ns
`default_nettype none
module host_i2c_model (
  input wire logic core_clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // idle bus: both lines released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // pin moves always follow a core edge
  task automatic hc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // 12-cycle half periods: slow enough for the slave's pin synchronisers
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    hc(6);
    scl <= 1'b1;
    hc(6);
    s = sda_line;
    hc(6);
    scl <= 1'b0;
    hc(6);
  endtask
  // also serves as repeated start, since scl may already be low
  task automatic start_cond;
    sda_low <= 1'b0;
    hc(6);
    scl <= 1'b1;
    hc(12);
    sda_low <= 1'b1;
    hc(12);
    scl <= 1'b0;
    hc(6);
  endtask
  task automatic stop_cond;
    sda_low <= 1'b1;
    hc(6);
    scl <= 1'b1;
    hc(12);
    sda_low <= 1'b0;
    hc(12);
  endtask
  // one byte out or in; ab is the acknowledge bit the host sends
  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ab, s);
    ack = !s;
  endtask
  // address, pointer, one data byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, r, a0);
    xfer(ptr, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // pointer set, restart, one byte read and closed by a nack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, r, a0);
    xfer(ptr, 1'b1, r, a1);
    start_cond();
    xfer({dev, 1'b1}, 1'b1, r, a2);
    xfer(8'hff, 1'b1, d, a3);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

/* File: dv/dual_card_mux_status_regs_test.sv */
/*
  self-checking bench for the card multiplexer register bank.
  assumes pull-ups on sda and the irq pin; strap therefore reads 1.
*/
`timescale 1ns/1ns
`default_nettype none
module dual_card_mux_status_regs_test;
  import card_mux_pkg::*;
  localparam logic [6:0] DEV = {SLAVE_ADDR_BASE[6:1], 1'b1};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tick_32k = 1'b0;
  logic shut = 1'b0;
  logic bat = 1'b0;
  wire logic scl;
  wire logic sda_low;
  logic sda_oe, irq_oe;
  logic [7:0] slot_control, device_control, clock_control, pull_config;
  int errors = 0;
  int tests_run = 0;
  int tick_cnt = 0;
  always #50 core_clk = ~core_clk;
  // 312-cycle period, close to 32 khz
  always @(posedge core_clk)
  begin
    tick_cnt <= (tick_cnt == 155) ? 0 : tick_cnt + 1;
    if (tick_cnt == 155)
      tick_32k <= ~tick_32k;
  end
  card_mux_regs dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .tick_32k(tick_32k),
    .shutdown_request_input(shut), .battery_sense_input(bat), .scl_in(scl),
    .sda_in(!(sda_low | sda_oe)), .sda_oe(sda_oe), .irq_in(!irq_oe), .irq_out(),
    .irq_oe(irq_oe), .slot_control(slot_control), .device_control(device_control),
    .clock_control(clock_control), .pull_config(pull_config));
  host_i2c_model host_u (.core_clk(core_clk), .scl(scl), .sda_low(sda_low), .sda_line(!(sda_low | sda_oe)));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic ok;
    host_u.read_reg(DEV, p, d, ok);
    check("read ack", {7'h0, ok}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host_u.write_reg(DEV, p, d, ok);
  endtask
  task automatic test_reset;
    logic [7:0] a[10] = '{ADDR_HW_REV, ADDR_SW_REV, ADDR_STATUS, ADDR_SLOT_CTRL, ADDR_BAT_DEB,
      ADDR_SDN_DEB, ADDR_RSVD, ADDR_CLK_CTRL, ADDR_DEV_CTRL, ADDR_PULL_CFG};
    logic [7:0] e[10] = '{{MAKER_CODE, HW_REV_CODE}, SW_REV_CODE, 8'h00, 8'h00, 8'h04,
      8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    check("control ports", slot_control | device_control | clock_control | pull_config, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      rd(a[i], d);
      check("reset value", d, e[i]);
    end
    $display("test reset done");
  endtask
  // read-only places, unmapped place and a foreign slave address
  task automatic test_refusals;
    logic [7:0] d;
    logic ok;
    wr(ADDR_HW_REV, 8'hff);
    wr(ADDR_SW_REV, 8'hff);
    rd(ADDR_HW_REV, d);
    check("hw revision", d, {MAKER_CODE, HW_REV_CODE});
    rd(ADDR_SW_REV, d);
    check("sw revision", d, SW_REV_CODE);
    rd(8'h20, d);
    check("unmapped", d, 8'h00);
    host_u.write_reg(DEV ^ 7'h01, ADDR_PULL_CFG, 8'h03, ok);
    check("foreign ack", {7'h0, ok}, 8'h00);
    check("pull port", pull_config, 8'h00);
    $display("test refusals done");
  endtask
  task automatic test_rw;
    logic [7:0] d;
    wr(ADDR_BAT_DEB, 8'h07);
    rd(ADDR_BAT_DEB, d);
    check("battery debounce", d, 8'h07);
    wr(ADDR_CLK_CTRL, 8'h80);
    wr(ADDR_PULL_CFG, 8'h03);
    wr(ADDR_DEV_CTRL, 8'h5a);
    check("clock port", clock_control, 8'h80);
    check("pull port", pull_config, 8'h03);
    check("device port", device_control, 8'h5a);
    wr(ADDR_DEV_CTRL, 8'h00);
    // the test bank is decoded as a range; touch one place inside it
    wr(ADDR_TEST_LO + 8'h02, 8'h3c);
    rd(ADDR_TEST_LO + 8'h02, d);
    check("test register", d, 8'h3c);
    $display("test rw done");
  endtask
  // every state with regulator off and on; slot two gets the inverse state
  task automatic test_slots;
    logic [7:0] d;
    logic [1:0] st;
    logic en;
    for (int i = 0; i < 8; i++)
    begin
      st = i[2:1];
      en = i[0];
      wr(ADDR_SLOT_CTRL, {~st, 1'b0, en, st, 1'b0, en});
      rd(ADDR_STATUS, d);
      check("slot one", {6'h0, d[5:4]}, {6'h0, en ? st : SLOT_DOWN});
      check("slot two", {6'h0, d[7:6]}, {6'h0, en ? ~st : SLOT_DOWN});
    end
    wr(ADDR_SLOT_CTRL, 8'h00);
    $display("test slots done");
  endtask
  task automatic test_shutdown;
    logic [7:0] d;
    wr(ADDR_SDN_DEB, 8'h02);
    wr(ADDR_DEV_CTRL, 8'h20);
    shut <= 1'b1;
    repeat (2500) @(posedge core_clk);
    check("irq pending", {7'h0, irq_oe}, 8'h01);
    rd(ADDR_STATUS, d);
    check("shutdown event", {6'h0, d[1:0]}, 8'h03);
    check("irq cleared", {7'h0, irq_oe}, 8'h00);
    rd(ADDR_STATUS, d);
    check("shutdown cleared", {6'h0, d[1:0]}, 8'h01);
    shut <= 1'b0;
    repeat (2500) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    check("shutdown low", {7'h0, d[0]}, 8'h00);
    $display("test shutdown done");
  endtask
  task automatic test_battery;
    logic [7:0] d;
    wr(ADDR_BAT_DEB, 8'h08);
    wr(ADDR_DEV_CTRL, 8'h04);
    bat <= 1'b1;
    rd(ADDR_STATUS, d);
    check("battery early", {6'h0, d[3:2]}, 8'h00);
    repeat (3000) @(posedge core_clk);
    check("irq pending", {7'h0, irq_oe}, 8'h01);
    rd(ADDR_STATUS, d);
    check("battery removed", {6'h0, d[3:2]}, 8'h03);
    rd(ADDR_STATUS, d);
    check("battery cleared", {6'h0, d[3:2]}, 8'h01);
    bat <= 1'b0;
    rd(ADDR_STATUS, d);
    check("battery back", {6'h0, d[3:2]}, 8'h00);
    $display("test battery done");
  endtask
  // cut a hang short well inside the cycle budget
  initial
  begin
    repeat (95000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    test_reset();
    test_refusals();
    test_rw();
    test_slots();
    test_shutdown();
    test_battery();
    give_verdict();
  end
endmodule
`default_nettype wire
